/* core/acs_cfg.svh */
// constants of the channel sequencer converter link
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_WORD_BITS 16
`define ACS_CTRL_BITS 12
`define ACS_RES_BITS 12
`define ACS_CTRL_LSB 4
`define ACS_LAST_BIT 4'hf
`define ACS_CTRL_EDGE 4'hb
`define ACS_WRITE_BIT 11
`define ACS_CYCLE_BIT 10
`define ACS_ADDR_HI 8
`define ACS_ADDR_LO 6
`define ACS_PM_HI 5
`define ACS_PM_LO 4
`define ACS_LIST_BIT 3
`define ACS_RANGE_BIT 1
`define ACS_CODING_BIT 0
`define ACS_PM_NORMAL 2'h3
`define ACS_PM_FULLDOWN 2'h2
`define ACS_PM_AUTO 2'h1
`define ACS_PM_INVALID 2'h0
`define ACS_CYC_SINGLE 2'h0
`define ACS_CYC_LOADLIST 2'h1
`define ACS_CYC_KEEP 2'h2
`define ACS_CYC_CONSEC 2'h3
`define ACS_CTRL_RST 12'h330
`define ACS_WAKE_NS 1000
`define ACS_CLK_NS 8
`define ACS_HALF_DEF 5
`define ACS_OFS_TX 12'h000
`define ACS_OFS_STATUS 12'h004
`define ACS_OFS_RX 12'h008
`define ACS_ST_BUSY 0
`define ACS_ST_DONE 1
`define ACS_ST_REFUSED 2
`endif

/* core/acs_device.sv */
// converter end: control word, channel list, sequencer and power modes
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "acs_cfg.svh"

// Contract
// - no cycling: convert channel from last address
// - power field 11 keeps converter fully up
// - power field 10 powers down, keeps control
// - power field 01 sleeps after updating conversion
// - host waits wake time before valid conversion; host code waits it only after a power field 01 write
// - host never writes power field 00
// - cycle bits 01 make next transfer list
// - list is 16 bits, falling edges, write-only
// - list loads only right after 01 write
// - list MSB first, upper byte sequence one
// - sequence one first; empty lower byte skipped
// - list runs ascending until non-10 write
// - cycle bits 10 keep sequence, take settings
// - cycle bits 11 run 0 to address
// - host leaves cycling by write with 00
// - control from first 12 falling edges
// - output: zero, channel, result, zero padding
module acs_device
  import acs_pkg::*;
#(
  parameter int RES_BITS = `ACS_RES_BITS
) (
  // link side
  acs_link_if.dev link,
  // reset of the link logic
  input wire logic rst,
  // conversion result from the analogue model
  input wire logic [RES_BITS-1:0] sampleCode,
  // state seen by the user
  output logic [2:0] convChannel,
  output logic poweredDown,
  output logic [1:0] cycleMode
);
  acs_dev_t s_r;
  acs_dev_t s_nxt;
  logic [`ACS_WORD_BITS-1:0] wordIn;
  logic [`ACS_CTRL_BITS-1:0] ctrlIn;
  logic [1:0] cycleBits;
  logic [2:0] addrNew;
  logic [1:0] pmNew;
  logic [`ACS_RES_BITS-1:0] codePadded;
  logic [3:0] stepPos;
  logic [3:0] firstPos;
  logic [3:0] newListPos;

  // next filled slot of the list after a position, wrapping
  function automatic logic [3:0] acs_list_step(
    input logic [`ACS_WORD_BITS-1:0] lst,
    input logic [3:0] pos
  );
    logic [3:0] res;
    logic [3:0] k;
    logic found;
    res = pos;
    found = 1'b0;
    for (int i = 1; i <= `ACS_WORD_BITS; i++) begin
      k = pos + 4'(i);
      if (!found && lst[`ACS_LAST_BIT - k]) begin
        res = k;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // fields of the arriving word
  assign wordIn = {s_r.shiftIn[`ACS_WORD_BITS-2:0], link.din};
  assign ctrlIn = wordIn[`ACS_CTRL_BITS-1:0];
  assign cycleBits = {s_r.ctrl[`ACS_CYCLE_BIT], s_r.ctrl[`ACS_LIST_BIT]};
  assign addrNew = s_r.ctrl[`ACS_ADDR_HI:`ACS_ADDR_LO];
  assign pmNew = s_r.ctrl[`ACS_PM_HI:`ACS_PM_LO];

  // narrower results sit high with trailing zeros
  assign codePadded = `ACS_RES_BITS'(sampleCode) << (`ACS_RES_BITS - RES_BITS);

  // list walk, sequence one slots 0..7 then sequence two 8..15
  assign stepPos = acs_list_step(s_r.chanList, s_r.listPos);
  assign firstPos = acs_list_step(wordIn, `ACS_LAST_BIT);
  assign newListPos = firstPos;

  // next state of the converter logic
  always_comb begin
    s_nxt = s_r;
    if (link.csN) begin
      s_nxt.bitCnt = '0;
    end else begin
      s_nxt.bitCnt = s_r.bitCnt + 4'h1;
      s_nxt.shiftIn = wordIn;
      // first edge: sample taken, word starts leaving
      if (s_r.bitCnt == '0) begin
        s_nxt.asleep = 1'b0;
        s_nxt.wrote = 1'b0;
        if (pmNew == `ACS_PM_FULLDOWN) begin
          // leading zero already stands on the idle line, channel follows
          {s_nxt.dout, s_nxt.shiftOut} = {s_r.chanCur, `ACS_RES_BITS'(0), 1'b0};
        end else begin
          {s_nxt.dout, s_nxt.shiftOut} = {s_r.chanCur, codePadded, 1'b0};
        end
      end else begin
        {s_nxt.dout, s_nxt.shiftOut} = {s_r.shiftOut, 1'b0};
      end
      // twelfth edge: control word complete
      if (s_r.bitCnt == `ACS_CTRL_EDGE && s_r.mode != ACS_ARM_LIST) begin
        if (ctrlIn[`ACS_WRITE_BIT]) begin
          s_nxt.ctrl = ctrlIn;
          s_nxt.wrote = 1'b1;
        end
      end
      // last edge: pick the channel of the next conversion
      if (s_r.bitCnt == `ACS_LAST_BIT) begin
        if (s_r.mode == ACS_ARM_LIST) begin
          s_nxt.chanList = wordIn;
          s_nxt.mode = ACS_LIST_RUN;
          s_nxt.listPos = newListPos;
          s_nxt.chanCur = newListPos[2:0];
        end else if (s_r.wrote) begin
          unique case (cycleBits)
            `ACS_CYC_SINGLE: begin
              s_nxt.mode = ACS_SINGLE;
              s_nxt.chanCur = addrNew;
            end
            `ACS_CYC_LOADLIST: begin
              s_nxt.mode = ACS_ARM_LIST;
              s_nxt.chanCur = addrNew;
            end
            `ACS_CYC_KEEP: begin
              // running cycle carries on with new settings
              unique case (s_r.mode)
                ACS_LIST_RUN: begin
                  s_nxt.listPos = stepPos;
                  s_nxt.chanCur = stepPos[2:0];
                end
                ACS_CONSEC: begin
                  s_nxt.chanCur = (s_r.chanCur == s_r.lastCh) ? 3'h0 : s_r.chanCur + 3'h1;
                end
                default: begin
                  s_nxt.mode = ACS_SINGLE;
                  s_nxt.chanCur = addrNew;
                end
              endcase
            end
            `ACS_CYC_CONSEC: begin
              s_nxt.mode = ACS_CONSEC;
              s_nxt.lastCh = addrNew;
              s_nxt.chanCur = 3'h0;
            end
          endcase
          // auto shutdown after a conversion that updated control
          s_nxt.asleep = (pmNew == `ACS_PM_AUTO);
        end else begin
          // no write: the cycle just steps on
          unique case (s_r.mode)
            ACS_LIST_RUN: begin
              s_nxt.listPos = stepPos;
              s_nxt.chanCur = stepPos[2:0];
            end
            ACS_CONSEC: begin
              s_nxt.chanCur = (s_r.chanCur == s_r.lastCh) ? 3'h0 : s_r.chanCur + 3'h1;
            end
            default: begin
              s_nxt.chanCur = s_r.chanCur;
            end
          endcase
        end
      end
    end
    // power state as the converter sees it
    unique case (s_nxt.ctrl[`ACS_PM_HI:`ACS_PM_LO])
      `ACS_PM_NORMAL: s_nxt.pwrDown = 1'b0;
      `ACS_PM_FULLDOWN: s_nxt.pwrDown = 1'b1;
      `ACS_PM_AUTO: s_nxt.pwrDown = s_nxt.asleep;
      default: s_nxt.pwrDown = 1'b0;
    endcase
  end

  // link logic runs on the link clock, falling edge samples din
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      s_r <= '{ctrl: `ACS_CTRL_RST, mode: ACS_SINGLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign link.dout = s_r.dout;
  assign convChannel = s_r.chanCur;
  assign poweredDown = s_r.pwrDown;
  assign cycleMode = s_r.mode;
endmodule
`default_nettype wire

/* core/acs_host.sv */
// host end: apb registers driving the serial converter link
`timescale 1ns/10ps
`default_nettype none
`include "acs_cfg.svh"
module acs_host
  import acs_pkg::*;
#(
  parameter int HALF = `ACS_HALF_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link side
  acs_link_if.host link
);
  localparam int WAKE = (`ACS_WAKE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS;
  localparam logic [7:0] HALF_LD = 8'(HALF - 1);
  localparam logic [7:0] WAKE_LD = 8'(WAKE - 1);

  acs_host_t s_r;
  acs_host_t s_nxt;
  logic doutSync;
  logic access;
  logic [`ACS_CTRL_BITS-1:0] ctrlW;

  // received data crosses from the link
  acs_sync #(.W(1)) u_sync (
    .clock(clock),
    .rst(rst),
    .d(link.dout),
    .q(doutSync)
  );

  assign access = psel && penable && s_r.pready;
  assign ctrlW = pwdata[`ACS_WORD_BITS-1:`ACS_CTRL_LSB];

  // register access and frame engine
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = '0;
    // read data and error prepared in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        `ACS_OFS_TX: s_nxt.prdata = 32'(s_r.txWord);
        `ACS_OFS_STATUS: s_nxt.prdata = 32'({s_r.refused, s_r.done, s_r.busy});
        `ACS_OFS_RX: s_nxt.prdata = 32'(s_r.rxWord);
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // write clears go first so a same-cycle set wins
    if (access && pwrite && paddr == `ACS_OFS_STATUS) begin
      if (pwdata[`ACS_ST_DONE]) s_nxt.done = 1'b0;
      if (pwdata[`ACS_ST_REFUSED]) s_nxt.refused = 1'b0;
    end
    unique case (s_r.state)
      ACS_IDLE: begin
        if (access && pwrite && paddr == `ACS_OFS_TX && !s_r.busy) begin
          if (!s_r.listArm && ctrlW[`ACS_WRITE_BIT]
              && ctrlW[`ACS_PM_HI:`ACS_PM_LO] == `ACS_PM_INVALID) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.txWord = pwdata[`ACS_WORD_BITS-1:0];
            s_nxt.txShift = {pwdata[`ACS_WORD_BITS-2:0], 1'b0};
            s_nxt.din = pwdata[`ACS_WORD_BITS-1];
            s_nxt.csN = 1'b0;
            s_nxt.sclk = 1'b1;
            s_nxt.cnt = HALF_LD;
            s_nxt.bitCnt = '0;
            s_nxt.busy = 1'b1;
            s_nxt.state = ACS_HIGH;
            s_nxt.wakeGap = 1'b0;
            if (s_r.listArm) begin
              s_nxt.listArm = 1'b0;
            end else if (ctrlW[`ACS_WRITE_BIT]) begin
              s_nxt.listArm = {ctrlW[`ACS_CYCLE_BIT], ctrlW[`ACS_LIST_BIT]} == `ACS_CYC_LOADLIST;
              s_nxt.wakeGap = ctrlW[`ACS_PM_HI:`ACS_PM_LO] == `ACS_PM_AUTO;
            end
          end
        end
      end
      ACS_HIGH: begin
        if (s_r.cnt == '0) begin
          s_nxt.shiftRx = {s_r.shiftRx[`ACS_WORD_BITS-2:0], doutSync};
          s_nxt.sclk = 1'b0;
          s_nxt.cnt = HALF_LD;
          s_nxt.state = ACS_LOW;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end
      end
      ACS_LOW: begin
        if (s_r.cnt == '0) begin
          s_nxt.sclk = 1'b1;
          s_nxt.cnt = HALF_LD;
          if (s_r.bitCnt == `ACS_LAST_BIT) begin
            s_nxt.state = ACS_TAIL;
          end else begin
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
            s_nxt.din = s_r.txShift[`ACS_WORD_BITS-1];
            s_nxt.txShift = {s_r.txShift[`ACS_WORD_BITS-2:0], 1'b0};
            s_nxt.state = ACS_HIGH;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end
      end
      ACS_TAIL: begin
        if (s_r.cnt == '0) begin
          s_nxt.csN = 1'b1;
          s_nxt.din = 1'b0;
          s_nxt.rxWord = s_r.shiftRx;
          s_nxt.cnt = s_r.wakeGap ? WAKE_LD : HALF_LD;
          s_nxt.state = ACS_GAP;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end
      end
      ACS_GAP: begin
        if (s_r.cnt == '0) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.state = ACS_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '{state: ACS_IDLE, sclk: 1'b1, csN: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign link.sclk = s_r.sclk;
  assign link.csN = s_r.csN;
  assign link.din = s_r.din;
endmodule
`default_nettype wire

/* core/acs_link_if.sv */
// serial link between the host port and the converter
`timescale 1ns/10ps
`default_nettype none
interface acs_link_if;
  logic sclk;
  logic csN;
  logic din;
  logic dout;
  modport dev (input sclk, input csN, input din, output dout);
  modport host (output sclk, output csN, output din, input dout);
endinterface
`default_nettype wire

/* core/acs_pkg.sv */
// types shared by both ends of the converter link
`include "acs_cfg.svh"
package acs_pkg;
  typedef enum logic [1:0] {ACS_SINGLE, ACS_ARM_LIST, ACS_LIST_RUN, ACS_CONSEC} acs_mode_t;
  typedef enum logic [2:0] {ACS_IDLE, ACS_HIGH, ACS_LOW, ACS_TAIL, ACS_GAP} acs_hstate_t;

  typedef struct packed {
    logic [`ACS_CTRL_BITS-1:0] ctrl;
    acs_mode_t mode;
    logic [2:0] chanCur;
    logic [3:0] listPos;
    logic [`ACS_WORD_BITS-1:0] chanList;
    logic [2:0] lastCh;
    logic [3:0] bitCnt;
    logic [`ACS_WORD_BITS-1:0] shiftIn;
    logic [`ACS_WORD_BITS-2:0] shiftOut;
    logic dout;
    logic wrote;
    logic asleep;
    logic pwrDown;
  } acs_dev_t;

  typedef struct packed {
    acs_hstate_t state;
    logic [7:0] cnt;
    logic [3:0] bitCnt;
    logic [`ACS_WORD_BITS-1:0] txWord;
    logic [`ACS_WORD_BITS-1:0] txShift;
    logic [`ACS_WORD_BITS-1:0] shiftRx;
    logic [`ACS_WORD_BITS-1:0] rxWord;
    logic sclk;
    logic csN;
    logic din;
    logic busy;
    logic done;
    logic refused;
    logic listArm;
    logic wakeGap;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acs_host_t;
endpackage

/* core/acs_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module acs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* verif/acs_link_asserts.sv */
// wire-level checks of the converter link
`timescale 1ns/10ps
`default_nettype none
module acs_link_asserts (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // link wires
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  input wire logic dout
);
  logic [4:0] fallCnt_r;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // clock falls counted inside a frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fallCnt_r <= 5'h00;
    end else if (csN) begin
      fallCnt_r <= 5'h00;
    end else if ($fell(sclk)) begin
      fallCnt_r <= fallCnt_r + 5'h01;
    end
  end

  idle_clock_a: assert property (csN |-> sclk) else $error("link clock low outside frame");
  lead_half_a: assert property ($fell(csN) |-> sclk [*5] ##1 !sclk) else $error("first fall misplaced");
  low_half_a: assert property ($fell(sclk) |-> !sclk [*5] ##1 sclk) else $error("low half wrong");
  din_hold_a: assert property (!sclk && $past(!sclk) |-> $stable(din)) else $error("din moved while low");
  frame_edges_a: assert property ($rose(csN) |-> fallCnt_r == 5'h10) else $error("frame not 16 falls");
  lead_zero_a: assert property ($fell(csN) |=> !dout [*4]) else $error("leading bit not zero");
  dout_edge_a: assert property ($changed(dout) |-> $fell(sclk) || $fell(csN) || $rose(csN))
    else $error("dout moved off a fall");
  frame_len_a: assert property ($fell(csN) |-> ##[164:166] $rose(csN)) else $error("frame length wrong");

  // main scenarios reached
  cover property ($rose(csN));
  cover property (!csN && dout);
  cover property ($rose(csN) ##[1:200] $fell(csN));
endmodule
`default_nettype wire

/* verif/adc_channel_sequencer_power_tb_top.sv */
// bench: apb host end and converter end joined over the link
`timescale 1ns/10ps
`default_nettype none
module adc_channel_sequencer_power_tb_top;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, poweredDown;
  logic [11:0] paddr, sampleCode;
  logic [31:0] pwdata, prdata, v;
  logic [2:0] convChannel, a, r, nc;
  logic [1:0] cycleMode;
  logic [15:0] lst, w;
  logic [2:0] ord[$];
  logic [32:0] expQ[$];
  int bad_count, total_checks, cycles;

  acs_link_if link();
  acs_host u_acs_host (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  acs_device u_acs_device (.link(link), .rst(rst), .sampleCode(sampleCode), .convChannel(convChannel),
    .poweredDown(poweredDown), .cycleMode(cycleMode));
  acs_link_asserts u_acs_link_asserts (.clock(clock), .rst(rst), .sclk(link.sclk), .csN(link.csN),
    .din(link.din), .dout(link.dout));

  // system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    logic [31:0] q;
    expQ.push_back(e);
    apb(1'b0, ad, 32'h0, q);
  endtask

  // one frame: start, wait done, clear, check received word
  task automatic send(input logic [15:0] wd, input logic [2:0] ch, input logic rx, input logic dn);
    logic [11:0] s;
    logic [31:0] q;
    s = 12'($urandom);
    sampleCode <= s;
    apb(1'b1, 12'h000, {16'h0, wd}, q);
    q = 32'h0;
    while (q[1] !== 1'b1) begin
      apb(1'b0, 12'h004, 32'h0, q);
    end
    apb(1'b1, 12'h004, 32'h2, q);
    if (rx) begin
      rd(12'h008, {18'h0, ch, dn ? 12'h000 : s});
    end
  endtask

  function automatic logic [15:0] cw(input logic wb, input logic [1:0] cyc, input logic [2:0] ad,
    input logic [1:0] pm);
    return {wb, cyc[1], 1'b0, ad, pm, cyc[0], 3'h0, 4'h0};
  endfunction

  // read answers compared against the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite && expQ.size() != 0) begin
      check({pslverr, prdata}, expQ.pop_front());
    end
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sampleCode = 12'h000;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(57031));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // one channel per write, every address once
    nc = 3'h0;
    r = 3'($urandom);
    for (int i = 0; i < 8; i++) begin
      a = 3'(i) + r;
      send(cw(1'b1, 2'h0, a, 2'h3), nc, 1'b1, 1'b0);
      nc = a;
      check({30'h0, convChannel}, {30'h0, a});
    end
    $display("test single done");
    // channel list armed, loaded and stepped
    a = 3'($urandom);
    send(cw(1'b1, 2'h1, a, 2'h3), nc, 1'b1, 1'b0);
    check({31'h0, cycleMode}, {31'h0, 2'h1});
    lst = {8'($urandom_range(255, 1)), 8'($urandom)};
    send(lst, a, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++) begin
      if (lst[15 - i]) ord.push_back(3'(i));
    end
    check({31'h0, cycleMode}, {31'h0, 2'h2});
    for (int k = 0; k < 12; k++) begin
      w = (k == 5) ? cw(1'b1, 2'h2, 3'h0, 2'h3) : {1'b0, 15'($urandom)};
      send(w, ord[k % ord.size()], 1'b1, 1'b0);
    end
    a = 3'($urandom);
    send(cw(1'b1, 2'h0, a, 2'h3), ord[12 % ord.size()], 1'b1, 1'b0);
    send(16'h0, a, 1'b1, 1'b0);
    check({31'h0, cycleMode}, {31'h0, 2'h0});
    $display("test list done");
    // consecutive channels up to the address
    r = 3'($urandom);
    send(cw(1'b1, 2'h3, r, 2'h3), a, 1'b1, 1'b0);
    nc = 3'h0;
    for (int k = 0; k < 2 * r + 3; k++) begin
      send(16'h0, nc, 1'b1, 1'b0);
      nc = (nc == r) ? 3'h0 : nc + 3'h1;
    end
    check({31'h0, cycleMode}, {31'h0, 2'h3});
    send(cw(1'b1, 2'h0, nc, 2'h3), nc, 1'b1, 1'b0);
    $display("test consecutive done");
    // power modes
    send(cw(1'b1, 2'h0, nc, 2'h2), nc, 1'b1, 1'b0);
    check({32'h0, poweredDown}, 33'h1);
    send(16'h0, nc, 1'b1, 1'b1);
    check({32'h0, poweredDown}, 33'h1);
    send(cw(1'b1, 2'h0, nc, 2'h3), nc, 1'b0, 1'b0);
    check({32'h0, poweredDown}, 33'h0);
    send(16'h0, nc, 1'b1, 1'b0);
    send(cw(1'b1, 2'h0, nc, 2'h1), nc, 1'b1, 1'b0);
    check({32'h0, poweredDown}, 33'h1);
    send(cw(1'b1, 2'h0, nc, 2'h3), nc, 1'b0, 1'b0);
    check({32'h0, poweredDown}, 33'h0);
    $display("test power done");
    // invalid power field refused, unmapped read
    apb(1'b1, 12'h000, {16'h0, cw(1'b1, 2'h0, nc, 2'h0)}, v);
    rd(12'h004, 33'h4);
    apb(1'b1, 12'h004, 32'h4, v);
    rd(12'h004, 33'h0);
    rd(12'h00c, {1'b1, 32'h0});
    rd(12'h000, {17'h0, cw(1'b1, 2'h0, nc, 2'h3)});
    $display("test refusal done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
